// File: esf_map.vh
`ifndef ESF_MAP_VH
`define ESF_MAP_VH
// ======================================
// Register offsets
`define ESF_ADDR_LINK_FLAGS 10'h023
`define ESF_ADDR_PRBS_FLAGS 10'h024
`define ESF_ADDR_CH0_FLAGS 10'h025
`define ESF_ADDR_LINK_SEL 10'h100
`define ESF_ADDR_PRBS_SEL 10'h101
`define ESF_ADDR_CH0_SEL 10'h102
`define ESF_ADDR_CTRL 10'h103
`define ESF_ADDR_BUF_FULL 10'h30C
`define ESF_ADDR_BUF_EMPTY 10'h30D
// ======================================
// Implemented bit masks per register
`define ESF_LINK_MASK 8'h06
`define ESF_PRBS_MASK 8'h05
`define ESF_CH0_MASK 8'hAC
// ======================================
// Field positions
`define ESF_BIT_PLL_LOCK 2
`define ESF_BIT_BUF_ERR 1
`define ESF_BIT_CH1_PRBS 2
`define ESF_BIT_CH0_PRBS 0
`define ESF_BIT_POWER 7
`define ESF_BIT_BLANK 5
`define ESF_BIT_ALIGN_LOCK 3
`define ESF_BIT_ALIGN_ROT 2
`define ESF_BIT_CTRL_LINK_EN 0
// ======================================
// Reset values
`define ESF_FLAGS_RST 8'h00
`define ESF_SEL_RST 8'h00
`define ESF_CTRL_RST 8'h0F
`endif

// File: esf_flag_bank.v
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Eight flags: live or rising-edge latched, write-one-to-clear
module esf_flag_bank #(
   parameter [7:0] IMPL = 8'hFF
) (
   input wire clk_in,
   input wire rst_in,
   input wire ce_in,
   input wire [7:0] src_in,
   input wire [7:0] sel_in,
   input wire clr_in,
   input wire [7:0] clr_data_in,
   output reg [7:0] flags_out,
   output reg [7:0] latched_out
);
   reg [7:0] src_d;
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1)
      begin : g_bit
         always @(posedge clk_in or posedge rst_in)
         begin
            if (rst_in)
            begin
               src_d[i] <= 1'b0;
               latched_out[i] <= 1'b0;
               flags_out[i] <= 1'b0;
            end
            else if (ce_in)
            begin
               src_d[i] <= src_in[i];
               if (!IMPL[i])
               begin
                  latched_out[i] <= 1'b0;
                  flags_out[i] <= 1'b0;
               end
               else if (!sel_in[i])
               begin
                  // Live view never raises the request
                  latched_out[i] <= 1'b0;
                  flags_out[i] <= src_in[i];
               end
               else if (src_in[i] && !src_d[i])
               begin
                  // Edge wins over a clear in the same cycle
                  latched_out[i] <= 1'b1;
                  flags_out[i] <= 1'b1;
               end
               else if (clr_in && clr_data_in[i])
               begin
                  latched_out[i] <= 1'b0;
                  flags_out[i] <= 1'b0;
               end
            end
         end
      end
   endgenerate
endmodule // esf_flag_bank
`default_nettype wire

// File: esf_lane_error.v
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Sticky lane buffer error, removed only by a link disable then enable
module esf_lane_error (
   input wire clk_in,
   input wire rst_in,
   input wire ce_in,
   input wire link_en_in,
   input wire [7:0] full_in,
   input wire [7:0] empty_in,
   output reg err_out,
   output reg [7:0] full_seen_out,
   output reg [7:0] empty_seen_out
);
   reg was_disabled;
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         err_out <= 1'b0;
         was_disabled <= 1'b0;
         full_seen_out <= 8'h00;
         empty_seen_out <= 8'h00;
      end
      else if (ce_in)
      begin
         if (!link_en_in)
         begin
            // Condition only drops on re-enable; disabled lanes are not judged
            was_disabled <= 1'b1;
         end
         else if (was_disabled)
         begin
            was_disabled <= 1'b0;
            err_out <= 1'b0;
            full_seen_out <= 8'h00;
            empty_seen_out <= 8'h00;
         end
         else
         begin
            full_seen_out <= full_seen_out | full_in;
            empty_seen_out <= empty_seen_out | empty_in;
            if (|full_in || |empty_in)
            begin
               err_out <= 1'b1;
            end
         end
      end
   end
endmodule // esf_lane_error
`default_nettype wire

// File: esf_event_latch.v
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "esf_map.vh"
// Summary of operation
// - Select high: rising source edge latches flag and pulls request low
// - Writing one clears a latched flag; zeros leave flags alone
// - Any lane buffer full or empty raises the buffer error at bit 1
// - Buffer error persists until link disabled then re-enabled
// - Per-lane full and empty indications in two separate registers
// - Link PLL lock reported at bit 2, one means locked
// - Pattern fail: channel 1 bit 2, channel 0 bit 0, others zero
// - Channel 0 power over threshold at bit 7
// - Channel 0 blanking complete at bit 5; bits 6 and 4 reserved
// - Channel 0 alignment locked at bit 3
// - Channel 0 alignment rotated at bit 2
// - Each event has its own read-write latch select bit
module esf_event_latch (
   input wire clk_in,
   input wire rst_in,
   input wire ce_in,
   input wire [9:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [7:0] rdata_out,
   input wire link_pll_locked_in,
   input wire [7:0] lane_full_in,
   input wire [7:0] lane_empty_in,
   input wire ch0_pattern_fail_in,
   input wire ch1_pattern_fail_in,
   input wire ch0_power_over_in,
   input wire ch0_blanking_complete_in,
   input wire ch0_align_locked_in,
   input wire ch0_align_rotated_in,
   output reg link_en_out,
   output reg irq_n_out,
   output reg irq_out
);
   // ======================================
   // Decode
   function sel_hit;
      input [9:0] a;
      input [9:0] cmp;
      begin
         sel_hit = (a == cmp);
      end
   endfunction

   reg [7:0] link_pll_fifo_sel;
   reg [7:0] prbs_sel;
   reg [7:0] ch0_sel;
   reg [7:0] irq_mask;
   wire [7:0] link_pll_fifo_flags;
   wire [7:0] prbs_error_flags;
   wire [7:0] channel0_event_flags;
   wire [7:0] link_latched;
   wire [7:0] prbs_latched;
   wire [7:0] ch0_latched;
   wire lane_buffer_error_flag;
   wire [7:0] full_seen;
   wire [7:0] empty_seen;
   wire [7:0] link_src;
   wire [7:0] prbs_src;
   wire [7:0] ch0_src;
   reg [7:0] next_rdata;
   wire any_latched;
   localparam [7:0] CTRL_RST = `ESF_CTRL_RST;

   // ======================================
   // Event sources into their bit positions
   assign link_src = {5'h00, link_pll_locked_in, lane_buffer_error_flag, 1'b0};
   assign prbs_src = {5'h00, ch1_pattern_fail_in, 1'b0, ch0_pattern_fail_in};
   assign ch0_src = {ch0_power_over_in, 1'b0, ch0_blanking_complete_in, 1'b0,
      ch0_align_locked_in, ch0_align_rotated_in, 2'h0};

   esf_lane_error u_lane (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .link_en_in(link_en_out),
      .full_in(lane_full_in),
      .empty_in(lane_empty_in),
      .err_out(lane_buffer_error_flag),
      .full_seen_out(full_seen),
      .empty_seen_out(empty_seen)
   );

   esf_flag_bank #(.IMPL(`ESF_LINK_MASK)) u_link (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .src_in(link_src),
      .sel_in(link_pll_fifo_sel),
      .clr_in(wr_in && sel_hit(addr_in, `ESF_ADDR_LINK_FLAGS)),
      .clr_data_in(wdata_in),
      .flags_out(link_pll_fifo_flags),
      .latched_out(link_latched)
   );

   esf_flag_bank #(.IMPL(`ESF_PRBS_MASK)) u_prbs (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .src_in(prbs_src),
      .sel_in(prbs_sel),
      .clr_in(wr_in && sel_hit(addr_in, `ESF_ADDR_PRBS_FLAGS)),
      .clr_data_in(wdata_in),
      .flags_out(prbs_error_flags),
      .latched_out(prbs_latched)
   );

   esf_flag_bank #(.IMPL(`ESF_CH0_MASK)) u_ch0 (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .src_in(ch0_src),
      .sel_in(ch0_sel),
      .clr_in(wr_in && sel_hit(addr_in, `ESF_ADDR_CH0_FLAGS)),
      .clr_data_in(wdata_in),
      .flags_out(channel0_event_flags),
      .latched_out(ch0_latched)
   );

   // ======================================
   // Register writes
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         link_pll_fifo_sel <= `ESF_SEL_RST;
         prbs_sel <= `ESF_SEL_RST;
         ch0_sel <= `ESF_SEL_RST;
         irq_mask <= {CTRL_RST[7:1], 1'b1};
         link_en_out <= CTRL_RST[`ESF_BIT_CTRL_LINK_EN];
      end
      else if (ce_in && wr_in)
      begin
         if (sel_hit(addr_in, `ESF_ADDR_LINK_SEL))
         begin
            link_pll_fifo_sel <= wdata_in & `ESF_LINK_MASK;
         end
         if (sel_hit(addr_in, `ESF_ADDR_PRBS_SEL))
         begin
            prbs_sel <= wdata_in & `ESF_PRBS_MASK;
         end
         if (sel_hit(addr_in, `ESF_ADDR_CH0_SEL))
         begin
            ch0_sel <= wdata_in & `ESF_CH0_MASK;
         end
         if (sel_hit(addr_in, `ESF_ADDR_CTRL))
         begin
            link_en_out <= wdata_in[`ESF_BIT_CTRL_LINK_EN];
            // Only three bank enables exist; the upper bits stay zero
            irq_mask <= {4'h0, wdata_in[3:1], 1'b1};
         end
      end
   end

   // ======================================
   // Read mux; unmapped addresses read zero
   always @*
   begin
      next_rdata = 8'h00;
      case (addr_in)
         `ESF_ADDR_LINK_FLAGS: next_rdata = link_pll_fifo_flags;
         `ESF_ADDR_PRBS_FLAGS: next_rdata = prbs_error_flags;
         `ESF_ADDR_CH0_FLAGS: next_rdata = channel0_event_flags;
         `ESF_ADDR_LINK_SEL: next_rdata = link_pll_fifo_sel;
         `ESF_ADDR_PRBS_SEL: next_rdata = prbs_sel;
         `ESF_ADDR_CH0_SEL: next_rdata = ch0_sel;
         `ESF_ADDR_CTRL: next_rdata = {irq_mask[7:1], link_en_out};
         `ESF_ADDR_BUF_FULL: next_rdata = full_seen;
         `ESF_ADDR_BUF_EMPTY: next_rdata = empty_seen;
         default: next_rdata = 8'h00;
      endcase
   end

   // Mask bit 0 is fixed on; upper ctrl bits gate the three banks
   assign any_latched = (irq_mask[1] && |link_latched) ||
      (irq_mask[2] && |prbs_latched) || (irq_mask[3] && |ch0_latched);

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rdata_out <= 8'h00;
         irq_n_out <= 1'b1;
         irq_out <= 1'b0;
      end
      else if (ce_in)
      begin
         rdata_out <= rd_in ? next_rdata : 8'h00;
         irq_n_out <= !any_latched;
         irq_out <= any_latched;
      end
   end
endmodule // esf_event_latch
`default_nettype wire

// File: esf_event_latch_props.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Port checks of the event flag latch
module esf_chk (
   input wire clk_in,
   input wire rst_in,
   input wire ce_in,
   input wire [9:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   input wire [7:0] rdata_out,
   input wire link_en_out,
   input wire irq_n_out,
   input wire irq_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   sequence s_rd(a);
      ce_in && rd_in && addr_in == a;
   endsequence
   a_rdata_idle: assert property (ce_in && !rd_in |=> rdata_out == 8'h00)
      else $error("read data outside read slot");
   a_freeze_hold: assert property (!ce_in |=> $stable(rdata_out) && $stable(irq_n_out) && $stable(link_en_out))
      else $error("outputs moved while clock enable low");
   a_prbs_reserved: assert property (s_rd(10'h024) |=> (rdata_out & 8'hFA) == 8'h00)
      else $error("pattern register reserved bit set");
   a_ch0_reserved: assert property (s_rd(10'h025) |=> (rdata_out & 8'h53) == 8'h00)
      else $error("channel register reserved bit set");
   a_link_reserved: assert property (s_rd(10'h023) |=> (rdata_out & 8'hF9) == 8'h00)
      else $error("link register reserved bit set");
   a_select_width: assert property (s_rd(10'h102) |=> (rdata_out & 8'h53) == 8'h00)
      else $error("select register reserved bit set");
   a_irq_polarity: assert property (irq_n_out == !irq_out)
      else $error("request outputs disagree");
   a_link_write: assert property (ce_in && wr_in && addr_in == 10'h103 |=> link_en_out == $past(wdata_in[0]))
      else $error("link enable not written");
   a_irq_quiet: assert property ($fell(rst_in) |-> irq_n_out [*3])
      else $error("request after reset");
   a_unmapped_zero: assert property (s_rd(10'h3FF) |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
endmodule // esf_chk
bind esf_event_latch esf_chk u_chk (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
   .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .link_en_out(link_en_out), .irq_n_out(irq_n_out),
   .irq_out(irq_out));
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [9:0] addr_in = 10'h000;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic ce = 1'b1;
   logic [6:0] ev = 7'h00;
   logic [7:0] full = 8'h00;
   logic [7:0] empty = 8'h00;
   wire [7:0] rdata_out;
   wire link_en_out;
   wire irq_n_out;
   wire irq_out;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   int k;
   logic [9:0] rst_tab [8] = '{10'h023, 10'h024, 10'h025, 10'h100, 10'h101, 10'h102, 10'h30C, 10'h3FF};
   always #2 clk_in = ~clk_in;
   esf_event_latch DUT (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .link_pll_locked_in(ev[0]), .lane_full_in(full),
      .lane_empty_in(empty), .ch0_pattern_fail_in(ev[1]), .ch1_pattern_fail_in(ev[2]), .ch0_power_over_in(ev[3]),
      .ch0_blanking_complete_in(ev[4]), .ch0_align_locked_in(ev[5]), .ch0_align_rotated_in(ev[6]),
      .link_en_out(link_en_out), .irq_n_out(irq_n_out), .irq_out(irq_out));
   function automatic logic [7:0] exp_flags(input logic [9:0] a, input logic [6:0] e);
      case (a)
         10'h023: exp_flags = {5'h00, e[0], 2'h0};
         10'h024: exp_flags = {5'h00, e[2], 1'h0, e[1]};
         default: exp_flags = {e[3], 1'h0, e[4], 1'h0, e[5], e[6], 2'h0};
      endcase
   endfunction
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("unexpected %s expected %h seen %h", name, exp, got);
         n_mismatch++;
      end
   endtask
   task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic reg_rd(input logic [9:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      check($sformatf("reg %h", a), exp, rdata_out);
   endtask
   task automatic irq_is(input int n, input logic [7:0] exp);
      repeat (n) @(posedge clk_in);
      #1;
      check("irq_n", exp, {7'h00, irq_n_out});
      check("irq", {7'h00, ~exp[0]}, {7'h00, irq_out});
   endtask
   task automatic complete_run;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ======================================
   // Hang guard
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         complete_run();
      end
   end
   // ======================================
   // Scenarios
   initial
   begin
      k = int'($urandom(95942));
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      foreach (rst_tab[i]) reg_rd(rst_tab[i], 8'h00);
      reg_rd(10'h103, 8'h0F);
      // Live mode with random sources
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk_in);
         ev <= 7'($urandom);
         repeat (2) @(posedge clk_in);
         for (int j = 0; j < 3; j++) reg_rd(10'h023 + 10'(j), exp_flags(10'h023 + 10'(j), ev));
         irq_is(0, 8'h01);
      end
      @(posedge clk_in);
      ev <= 7'h00;
      reg_wr(10'h100, 8'hFF);
      reg_wr(10'h101, 8'hFF);
      reg_wr(10'h102, 8'hFF);
      reg_rd(10'h100, 8'h06);
      reg_rd(10'h101, 8'h05);
      reg_rd(10'h102, 8'hAC);
      // Edges latch, then the sources drop again
      @(posedge clk_in);
      ev <= 7'h7F;
      repeat (3) @(posedge clk_in);
      ev <= 7'h00;
      irq_is(0, 8'h00);
      reg_rd(10'h023, 8'h04);
      reg_rd(10'h024, 8'h05);
      reg_rd(10'h025, 8'hAC);
      reg_wr(10'h103, 8'h01);
      irq_is(2, 8'h01);
      reg_wr(10'h103, 8'h0F);
      irq_is(2, 8'h00);
      reg_wr(10'h024, 8'h01);
      reg_rd(10'h024, 8'h04);
      reg_wr(10'h025, 8'hAC);
      reg_wr(10'h023, 8'h04);
      irq_is(2, 8'h00);
      reg_wr(10'h024, 8'h04);
      irq_is(2, 8'h01);
      reg_rd(10'h025, 8'h00);
      // Lane buffer error, link bank in live mode
      reg_wr(10'h100, 8'h00);
      k = $urandom_range(7);
      @(posedge clk_in);
      full <= 8'h01 << k;
      @(posedge clk_in);
      full <= 8'h00;
      empty <= 8'h80 >> k;
      @(posedge clk_in);
      empty <= 8'h00;
      reg_rd(10'h023, 8'h02);
      reg_rd(10'h30C, 8'h01 << k);
      reg_rd(10'h30D, 8'h80 >> k);
      reg_wr(10'h103, 8'h0E);
      reg_rd(10'h023, 8'h02);
      reg_wr(10'h103, 8'h0F);
      repeat (2) @(posedge clk_in);
      reg_rd(10'h023, 8'h00);
      reg_rd(10'h30C, 8'h00);
      // Clock enable low: the write is dropped, the edge waits until it returns
      @(posedge clk_in);
      ce <= 1'b0;
      reg_wr(10'h101, 8'h00);
      ev <= 7'h02;
      irq_is(2, 8'h01);
      @(posedge clk_in);
      ce <= 1'b1;
      irq_is(2, 8'h00);
      reg_rd(10'h101, 8'h05);
      // Edge and clear in one cycle: the edge wins
      @(posedge clk_in);
      ev <= 7'h00;
      reg_wr(10'h024, 8'h01);
      reg_rd(10'h024, 8'h00);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= 10'h024;
      wdata_in <= 8'h01;
      ev <= 7'h02;
      @(posedge clk_in);
      wr_in <= 1'b0;
      ev <= 7'h00;
      reg_rd(10'h024, 8'h01);
      irq_is(0, 8'h00);
      reg_wr(10'h024, 8'h01);
      reg_rd(10'h024, 8'h00);
      irq_is(0, 8'h01);
      complete_run();
   end
endmodule // testbench
`default_nettype wire
